// File: hw/ssrp_pkg.sv
// constants, offsets and types shared by the serial register port
package ssrp_pkg;

    // ========================================================
    // primary bank byte addresses (even byte = high half)
    localparam logic [5:0] ADDR_EXT_WR_HIGH = 6'h04;
    localparam logic [5:0] ADDR_EXT_WR_LOW  = 6'h06;
    localparam logic [5:0] ADDR_EXT_WR_ADDR = 6'h08;
    localparam logic [5:0] ADDR_EXT_WR_CMD  = 6'h0A;
    localparam logic [5:0] ADDR_EXT_RD_ADDR = 6'h0C;
    localparam logic [5:0] ADDR_EXT_RD_CMD  = 6'h0E;
    localparam logic [5:0] ADDR_EXT_RD_HIGH = 6'h10;
    localparam logic [5:0] ADDR_EXT_RD_LOW  = 6'h12;
    localparam logic [5:0] ADDR_STATUS      = 6'h14;
    localparam logic [5:0] ADDR_TURNS_HIGH  = 6'h16;
    localparam logic [5:0] ADDR_TURNS_LOW   = 6'h18;
    localparam logic [5:0] ADDR_OUT_CTRL    = 6'h1A;
    localparam logic [5:0] ADDR_CMD         = 6'h1C;

    // ========================================================
    // command field values
    localparam logic [7:0] CMD_LOAD_ACCUM  = 8'h03;
    localparam logic [7:0] CMD_RESET_TURNS = 8'h01;
    localparam logic [7:0] CMD_TRIGGER_KEY = 8'h46;

    // ========================================================
    // field positions
    localparam int EXT_GO          = 0;
    localparam int EXT_DONE        = 1;
    localparam int EXT_BLOCKED     = 2;
    localparam int STAT_ALL_OK     = 0;
    localparam int STAT_IFACE_ERR  = 1;
    localparam int STAT_CRC_ERR    = 2;
    localparam int OUT_SPI_SEL     = 0;
    localparam int CFG_INIT_LSB    = 0;
    localparam int CFG_SUPPLY_DIS  = 2;
    localparam int CFG_CRC_CHECK   = 3;
    localparam int CFG_LATE_SAMPLE = 4;
    localparam int CFG_PWM_EN      = 5;
    localparam int CFG_SENT_EN     = 6;
    localparam int CFG_LOCK        = 7;

    // ========================================================
    // sizes, counts and reset values
    localparam int         EXT_IDX_W   = 3;
    localparam int         EXT_DEPTH   = 8;
    localparam logic [2:0] CFG_INDEX   = 3'h0;
    localparam logic [4:0] FRAME_SHORT = 5'h10;
    localparam logic [4:0] FRAME_LATE  = 5'h11;
    localparam logic [4:0] FRAME_CRC   = 5'h14;
    localparam logic [4:0] COUNT_MAX   = 5'h1F;
    localparam logic [3:0] CRC_PRESET  = 4'hF;
    localparam logic [20:0] ACCUM_RST  = 21'h0_0000;
    localparam logic [31:0] EXT_RST    = 32'h0000_0000;
    localparam logic [15:0] REG_RST    = 16'h0000;

    // ========================================================
    // link state and output pin owner
    typedef enum logic [1:0] {
        LINK_IDLE  = 2'b01,
        LINK_FRAME = 2'b10
    } ssrp_link_e;

    typedef enum logic [3:0] {
        OWN_SPI    = 4'b0001,
        OWN_SUPPLY = 4'b0010,
        OWN_PWM    = 4'b0100,
        OWN_SENT   = 4'b1000
    } ssrp_owner_e;

endpackage

// File: hw/ssrp_port.sv
// serial register port: spi slave, primary bank, extended window, turn accumulator
//
// Contract
// - reset command code zeroes the turn accumulator
// - accumulator registers are read-only over the serial bank
// - code 0x03 plus key 0x46 starts the accumulator load
// - startup setting 00 or 01: loaded value copied straight in
// - startup setting 10 or 11: value snapped to the sensed angle
// - supply-line commands ignored when its disable bit is set
// - nonvolatile lock blocks extended writes from both paths
// - output pin owner by fixed priority, spi by default
// - extended write uses address, data high, data low, command/status registers
// - extended read uses address, command/status, data high and low registers
// - both serial paths write through the primary bank; only spi can read it back
// - device is spi slave only, link clocked up to 10 MHz
// - frames of 16 or 20 clocks, or only 17 with option set
// - 20-clock frames carry a 4-bit crc after the payload
// - wrong clock count sets the interface warning
// - write frame: zero, rw high, 6 address, 8 data, optional crc
// - mosi taken on rising sclk, frame committed on chip select rise
// - miso carries previously selected read data, a zero word before any read
// - crc bits follow the data on miso past the 16th clock
// - crc x^4+x+1, preset all ones, payload msb first
// - with crc check on, bad crc frames dropped and crc warning set
// - read selects a register, its word returns in the next frame
// - odd read address returns one byte, upper byte zero
`timescale 1ns/1ps

module ssrp_port (
    input  wire logic        clock,               // core clock
    input  wire logic        sys_rst,             // synchronous reset, active high
    input  wire logic        spiSclk,             // serial clock from host
    input  wire logic        spiCsN,              // chip select, active low
    input  wire logic        spiMosi,             // serial data from host
    output logic             spiMiso,             // serial data to host
    output logic             spiMisoOe,           // miso drive enable
    input  wire logic        supplyWrValid,       // supply-line byte write strobe
    input  wire logic [5:0]  supplyWrAddr,        // supply-line byte address
    input  wire logic [7:0]  supplyWrData,        // supply-line byte data
    input  wire logic        supplySessionActive, // supply-line session running
    input  wire logic        systemAllOk,         // system stable indication
    input  wire logic        angleDeltaValid,     // angle change strobe
    input  wire logic [20:0] angleDelta,          // signed angle change
    input  wire logic [11:0] sensedAngle,         // current angle code
    output logic [20:0]      turnsPosition,       // turn accumulator value
    output logic [3:0]       sharedOutputPinOwner,// one-hot owner of output pin
    output logic             interfaceErrorWarning // clock-count warning flag
);

    // ========================================================
    // helpers
    function automatic logic [3:0] crc4(input logic [15:0] data);
        logic [3:0] c;
        logic       inv;
        c = ssrp_pkg::CRC_PRESET;
        for (int i = 15; i >= 0; i--)
        begin
            inv = data[i] ^ c[3];
            c   = {c[2], c[1], c[0] ^ inv, inv};
        end
        return c;
    endfunction

    function automatic logic hit(input logic [5:0] addr, input logic [5:0] base);
        return addr[5:1] == base[5:1];
    endfunction

    function automatic logic [15:0] putByte(input logic [15:0] old, input logic odd,
                                            input logic [7:0] b);
        return odd ? {old[15:8], b} : {b, old[7:0]};
    endfunction

    // ========================================================
    // link input synchronisers and edge detection
    logic [2:0] sclkSync_ff;
    logic [2:0] csSync_ff;
    logic [1:0] mosiSync_ff;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            sclkSync_ff <= 3'h7;
            csSync_ff   <= 3'h7;
            mosiSync_ff <= 2'h0;
        end
        else
        begin
            sclkSync_ff <= {sclkSync_ff[1:0], spiSclk};
            csSync_ff   <= {csSync_ff[1:0], spiCsN};
            mosiSync_ff <= {mosiSync_ff[0], spiMosi};
        end
    end

    logic sclkRise;
    logic sclkFall;
    logic csRise;
    logic csFall;
    assign sclkRise = sclkSync_ff[1] & ~sclkSync_ff[2];
    assign sclkFall = ~sclkSync_ff[1] & sclkSync_ff[2];
    assign csRise   = csSync_ff[1] & ~csSync_ff[2];
    assign csFall   = ~csSync_ff[1] & csSync_ff[2];

    // ========================================================
    // frame receive
    ssrp_pkg::ssrp_link_e linkState_ff;
    logic [4:0]  bitCnt_ff;
    logic [19:0] shiftIn_ff;
    logic        inFrame;
    assign inFrame = linkState_ff == ssrp_pkg::LINK_FRAME;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            linkState_ff <= ssrp_pkg::LINK_IDLE;
        end
        else
        begin
            case (linkState_ff)
                ssrp_pkg::LINK_IDLE:
                    if (csFall)
                        linkState_ff <= ssrp_pkg::LINK_FRAME;
                ssrp_pkg::LINK_FRAME:
                    if (csRise)
                        linkState_ff <= ssrp_pkg::LINK_IDLE;
                default:
                    linkState_ff <= ssrp_pkg::LINK_IDLE;
            endcase
        end
    end

    // slave only: sclk and chip select come from the host
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            bitCnt_ff  <= 5'h00;
            shiftIn_ff <= 20'h0_0000;
        end
        else if (csFall)
        begin
            bitCnt_ff  <= 5'h00;
        end
        else if (inFrame && sclkRise)
        begin
            shiftIn_ff <= {shiftIn_ff[18:0], mosiSync_ff[1]};
            if (bitCnt_ff != ssrp_pkg::COUNT_MAX)
                bitCnt_ff <= bitCnt_ff + 5'h01;
        end
    end

    logic [31:0] extMem_ff [ssrp_pkg::EXT_DEPTH];
    logic [31:0] cfgWord;
    assign cfgWord = extMem_ff[ssrp_pkg::CFG_INDEX];

    logic        lateOpt;
    logic [15:0] payload;
    logic        lenOk;
    logic        crcBad;
    logic        frameGood;
    logic        spiWrite;
    logic        spiReadSel;
    assign lateOpt = cfgWord[ssrp_pkg::CFG_LATE_SAMPLE];

    always_comb
    begin
        payload = shiftIn_ff[15:0];
        if (bitCnt_ff == ssrp_pkg::FRAME_LATE)
            payload = shiftIn_ff[16:1];
        else if (bitCnt_ff == ssrp_pkg::FRAME_CRC)
            payload = shiftIn_ff[19:4];
    end

    assign lenOk = lateOpt ? (bitCnt_ff == ssrp_pkg::FRAME_LATE)
                           : (bitCnt_ff == ssrp_pkg::FRAME_SHORT ||
                              bitCnt_ff == ssrp_pkg::FRAME_CRC);
    assign crcBad = cfgWord[ssrp_pkg::CFG_CRC_CHECK] && bitCnt_ff == ssrp_pkg::FRAME_CRC &&
                    shiftIn_ff[3:0] != crc4(payload);
    assign frameGood  = inFrame && csRise && lenOk && !crcBad && !payload[15];
    assign spiWrite   = frameGood && payload[14];
    assign spiReadSel = frameGood && !payload[14];

    // ========================================================
    // byte write port shared by both paths
    logic       wrEn;
    logic [5:0] wrAddr;
    logic [7:0] wrData;

    // spi wins a same-cycle collision; the supply byte is then lost
    always_comb
    begin
        wrEn   = 1'b0;
        wrAddr = payload[13:8];
        wrData = payload[7:0];
        if (spiWrite)
        begin
            wrEn = 1'b1;
        end
        else if (supplyWrValid && !cfgWord[ssrp_pkg::CFG_SUPPLY_DIS])
        begin
            wrEn   = 1'b1;
            wrAddr = supplyWrAddr;
            wrData = supplyWrData;
        end
    end

    function automatic logic wrHit(input logic en, input logic [5:0] a,
                                   input logic [5:0] base);
        return en && hit(a, base);
    endfunction

    // ========================================================
    // primary bank storage
    logic [15:0] extWrHigh_ff;
    logic [15:0] extWrLow_ff;
    logic [15:0] extWrAddr_ff;
    logic [15:0] extRdAddr_ff;
    logic        spiOutSel_ff;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            extWrHigh_ff <= ssrp_pkg::REG_RST;
            extWrLow_ff  <= ssrp_pkg::REG_RST;
            extWrAddr_ff <= ssrp_pkg::REG_RST;
            extRdAddr_ff <= ssrp_pkg::REG_RST;
            spiOutSel_ff <= 1'b0;
        end
        else if (wrEn)
        begin
            if (hit(wrAddr, ssrp_pkg::ADDR_EXT_WR_HIGH))
                extWrHigh_ff <= putByte(extWrHigh_ff, wrAddr[0], wrData);
            else if (hit(wrAddr, ssrp_pkg::ADDR_EXT_WR_LOW))
                extWrLow_ff <= putByte(extWrLow_ff, wrAddr[0], wrData);
            else if (hit(wrAddr, ssrp_pkg::ADDR_EXT_WR_ADDR))
                extWrAddr_ff <= putByte(extWrAddr_ff, wrAddr[0], wrData);
            else if (hit(wrAddr, ssrp_pkg::ADDR_EXT_RD_ADDR))
                extRdAddr_ff <= putByte(extRdAddr_ff, wrAddr[0], wrData);
            else if (wrAddr == (ssrp_pkg::ADDR_OUT_CTRL | 6'h01))
                spiOutSel_ff <= wrData[ssrp_pkg::OUT_SPI_SEL];
        end
    end

    // ========================================================
    // extended memory window
    logic        extWrGo;
    logic        extRdGo;
    logic        extWrDone_ff;
    logic        extWrBlocked_ff;
    logic        extRdDone_ff;
    logic [15:0] extRdHigh_ff;
    logic [15:0] extRdLow_ff;

    assign extWrGo = wrHit(wrEn, wrAddr, ssrp_pkg::ADDR_EXT_WR_CMD) && wrAddr[0] &&
                     wrData[ssrp_pkg::EXT_GO];
    assign extRdGo = wrHit(wrEn, wrAddr, ssrp_pkg::ADDR_EXT_RD_CMD) && wrAddr[0] &&
                     wrData[ssrp_pkg::EXT_GO];

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < ssrp_pkg::EXT_DEPTH; i++)
                extMem_ff[i] <= ssrp_pkg::EXT_RST;
            extWrDone_ff    <= 1'b0;
            extWrBlocked_ff <= 1'b0;
        end
        else if (extWrGo)
        begin
            if (cfgWord[ssrp_pkg::CFG_LOCK])
            begin
                extWrBlocked_ff <= 1'b1;
                extWrDone_ff    <= 1'b0;
            end
            else
            begin
                extMem_ff[extWrAddr_ff[ssrp_pkg::EXT_IDX_W-1:0]] <= {extWrHigh_ff, extWrLow_ff};
                extWrBlocked_ff <= 1'b0;
                extWrDone_ff    <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            extRdDone_ff <= 1'b0;
            extRdHigh_ff <= ssrp_pkg::REG_RST;
            extRdLow_ff  <= ssrp_pkg::REG_RST;
        end
        else if (extRdGo)
        begin
            {extRdHigh_ff, extRdLow_ff} <= extMem_ff[extRdAddr_ff[ssrp_pkg::EXT_IDX_W-1:0]];
            extRdDone_ff <= 1'b1;
        end
    end

    // ========================================================
    // command register and turn accumulator
    logic [7:0] cmdKey_ff;
    logic [7:0] cmdCode_ff;
    logic       cmdFire;
    assign cmdFire = cmdKey_ff == ssrp_pkg::CMD_TRIGGER_KEY;

    // a fresh write in the firing cycle re-arms instead of being cleared
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            cmdKey_ff  <= 8'h00;
            cmdCode_ff <= 8'h00;
        end
        else if (wrHit(wrEn, wrAddr, ssrp_pkg::ADDR_CMD))
        begin
            if (wrAddr[0])
                cmdCode_ff <= wrData;
            else
                cmdKey_ff <= wrData;
        end
        else if (cmdFire)
        begin
            cmdKey_ff  <= 8'h00;
            cmdCode_ff <= 8'h00;
        end
    end

    logic [20:0] accum_ff;
    logic [20:0] loadValue;
    logic [11:0] angleDiff;
    logic [20:0] snapValue;
    assign loadValue = {extWrHigh_ff[4:0], extWrLow_ff};
    // 12-bit wrap keeps the correction within half a turn
    assign angleDiff = sensedAngle - loadValue[11:0];
    assign snapValue = loadValue + {{9{angleDiff[11]}}, angleDiff};

    // only commands and angle deltas touch this; no bank write path reaches it
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            accum_ff <= ssrp_pkg::ACCUM_RST;
        end
        else if (cmdFire && cmdCode_ff == ssrp_pkg::CMD_RESET_TURNS)
        begin
            accum_ff <= ssrp_pkg::ACCUM_RST;
        end
        else if (cmdFire && cmdCode_ff == ssrp_pkg::CMD_LOAD_ACCUM)
        begin
            if (cfgWord[ssrp_pkg::CFG_INIT_LSB + 1])
                accum_ff <= snapValue;
            else
                accum_ff <= loadValue;
        end
        else if (angleDeltaValid)
        begin
            accum_ff <= accum_ff + angleDelta;
        end
    end

    // ========================================================
    // warning flags, write one to clear, set wins
    logic ierWarn_ff;
    logic crcWarn_ff;
    logic statClr;
    logic ierSet;
    assign statClr = wrEn && wrAddr == (ssrp_pkg::ADDR_STATUS | 6'h01);
    assign ierSet  = inFrame && csRise && !lenOk;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            ierWarn_ff <= 1'b0;
            crcWarn_ff <= 1'b0;
        end
        else
        begin
            if (ierSet)
                ierWarn_ff <= 1'b1;
            else if (statClr && wrData[ssrp_pkg::STAT_IFACE_ERR])
                ierWarn_ff <= 1'b0;
            if (inFrame && csRise && lenOk && crcBad)
                crcWarn_ff <= 1'b1;
            else if (statClr && wrData[ssrp_pkg::STAT_CRC_ERR])
                crcWarn_ff <= 1'b0;
        end
    end

    // ========================================================
    // read selection and miso
    logic [5:0]  readSel_ff;
    logic        readValid_ff;
    logic [15:0] regWord;
    logic [15:0] readWord;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            readSel_ff   <= 6'h00;
            readValid_ff <= 1'b0;
        end
        else if (spiReadSel)
        begin
            readSel_ff   <= payload[13:8];
            readValid_ff <= 1'b1;
        end
    end

    always_comb
    begin
        regWord = ssrp_pkg::REG_RST;
        if (hit(readSel_ff, ssrp_pkg::ADDR_EXT_WR_HIGH))
            regWord = extWrHigh_ff;
        else if (hit(readSel_ff, ssrp_pkg::ADDR_EXT_WR_LOW))
            regWord = extWrLow_ff;
        else if (hit(readSel_ff, ssrp_pkg::ADDR_EXT_WR_ADDR))
            regWord = extWrAddr_ff;
        else if (hit(readSel_ff, ssrp_pkg::ADDR_EXT_WR_CMD))
            regWord = {13'h0000, extWrBlocked_ff, extWrDone_ff, 1'b0};
        else if (hit(readSel_ff, ssrp_pkg::ADDR_EXT_RD_ADDR))
            regWord = extRdAddr_ff;
        else if (hit(readSel_ff, ssrp_pkg::ADDR_EXT_RD_CMD))
            regWord = {14'h0000, extRdDone_ff, 1'b0};
        else if (hit(readSel_ff, ssrp_pkg::ADDR_EXT_RD_HIGH))
            regWord = extRdHigh_ff;
        else if (hit(readSel_ff, ssrp_pkg::ADDR_EXT_RD_LOW))
            regWord = extRdLow_ff;
        else if (hit(readSel_ff, ssrp_pkg::ADDR_STATUS))
            regWord = {13'h0000, crcWarn_ff, ierWarn_ff, systemAllOk};
        else if (hit(readSel_ff, ssrp_pkg::ADDR_TURNS_HIGH))
            regWord = {11'h000, accum_ff[20:16]};
        else if (hit(readSel_ff, ssrp_pkg::ADDR_TURNS_LOW))
            regWord = accum_ff[15:0];
        else if (hit(readSel_ff, ssrp_pkg::ADDR_OUT_CTRL))
            regWord = {15'h0000, spiOutSel_ff};
        else if (hit(readSel_ff, ssrp_pkg::ADDR_CMD))
            regWord = {cmdKey_ff, cmdCode_ff};
    end

    assign readWord = !readValid_ff ? 16'h0000 :
                      readSel_ff[0] ? {8'h00, regWord[7:0]} : regWord;

    logic [19:0] txShift_ff;
    logic        spiMiso_ff;
    logic        spiMisoOe_ff;

    // bit goes out on each falling edge; a falling-edge sampler needs the extra clock
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            txShift_ff   <= 20'h0_0000;
            spiMiso_ff   <= 1'b0;
            spiMisoOe_ff <= 1'b0;
        end
        else if (csFall)
        begin
            txShift_ff   <= {readWord, crc4(readWord)};
            spiMiso_ff   <= 1'b0;
            spiMisoOe_ff <= 1'b1;
        end
        else if (inFrame && csRise)
        begin
            spiMisoOe_ff <= 1'b0;
            spiMiso_ff   <= 1'b0; // last crc bit must not linger on the idle line
        end
        else if (inFrame && sclkFall)
        begin
            spiMiso_ff <= txShift_ff[19];
            txShift_ff <= {txShift_ff[18:0], 1'b0};
        end
    end

    // ========================================================
    // output pin owner
    ssrp_pkg::ssrp_owner_e owner_ff;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            owner_ff <= ssrp_pkg::OWN_SPI;
        else if (supplySessionActive && !cfgWord[ssrp_pkg::CFG_SUPPLY_DIS])
            owner_ff <= ssrp_pkg::OWN_SUPPLY;
        else if (spiOutSel_ff)
            owner_ff <= ssrp_pkg::OWN_SPI;
        else if (cfgWord[ssrp_pkg::CFG_PWM_EN])
            owner_ff <= ssrp_pkg::OWN_PWM;
        else if (cfgWord[ssrp_pkg::CFG_SENT_EN])
            owner_ff <= ssrp_pkg::OWN_SENT;
        else
            owner_ff <= ssrp_pkg::OWN_SPI;
    end

    assign spiMiso               = spiMiso_ff;
    assign spiMisoOe             = spiMisoOe_ff;
    assign turnsPosition         = accum_ff;
    assign sharedOutputPinOwner  = owner_ff;
    assign interfaceErrorWarning = ierWarn_ff;

endmodule

// File: dv/ssrp_host_model.sv
// spi master model standing in for the host controller
`timescale 1ns/1ps
module ssrp_host_model (
    output logic     spiSclk, // serial clock
    output logic     spiCsN,  // chip select
    output logic     spiMosi, // data to device
    input wire logic spiMiso  // data from device
);
    initial {spiSclk, spiCsN, spiMosi} = 3'b110;
    // ========================================
    // clock runs only inside frames; released data line is inverted
    task automatic xfer(input logic [19:0] tx, input int n, output logic [19:0] rx);
        rx = '0;
        spiCsN = 1'b0;
        #100;
        for (int i = 0; i < n; i++)
        begin
            spiSclk = 1'b0;
            spiMosi = tx[19 - i];
            #40 spiSclk = 1'b1;
            #40 rx = {rx[18:0], spiMiso};
        end
        spiCsN = 1'b1;
        spiMosi = ~spiMosi;
        #300;
    endtask
endmodule

// File: dv/ssrp_port_monitor.sv
// assertion checker for the serial register port
`timescale 1ns/1ps
module ssrp_port_monitor (
    input wire logic        clock,                 // core clock
    input wire logic        sys_rst,               // reset
    input wire logic        spiCsN,                // select
    input wire logic        spiMiso,               // data out
    input wire logic        spiMisoOe,             // enable
    input wire logic        supplyWrValid,         // supply write
    input wire logic        supplySessionActive,   // session
    input wire logic        angleDeltaValid,       // delta strobe
    input wire logic [20:0] angleDelta,            // delta
    input wire logic [20:0] turnsPosition,         // accumulator
    input wire logic [3:0]  sharedOutputPinOwner,  // pin owner
    input wire logic        interfaceErrorWarning  // warning
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // ========================================
    // idle long enough that no judged frame is still in flight
    sequence idle8; (spiCsN && !supplyWrValid)[*8]; endsequence
    owner_onehot_a: assert property ($onehot(sharedOutputPinOwner)) else $error("owner");
    owner_session_a: assert property (!supplySessionActive[*3] |->
        sharedOutputPinOwner != ssrp_pkg::OWN_SUPPLY) else $error("owner session");
    oe_idle_a: assert property (spiCsN[*5] |-> !spiMisoOe) else $error("oe idle");
    miso_idle_a: assert property (spiCsN[*8] |-> !spiMiso) else $error("miso idle");
    oe_open_a: assert property ($fell(spiCsN) |-> ##[2:5] spiMisoOe) else $error("oe");
    turns_hold_a: assert property (idle8 ##0 !angleDeltaValid |=>
        $stable(turnsPosition)) else $error("turns moved");
    turns_add_a: assert property (idle8 ##0 angleDeltaValid |=>
        turnsPosition == $past(turnsPosition) + $past(angleDelta)) else $error("turns add");
    warn_cause_a: assert property (idle8 |=> !$rose(interfaceErrorWarning))
        else $error("warning");
endmodule
bind ssrp_port ssrp_port_monitor i_ssrp_port_monitor (.clock(clock), .sys_rst(sys_rst),
    .spiCsN(spiCsN), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .supplyWrValid(supplyWrValid),
    .supplySessionActive(supplySessionActive), .angleDeltaValid(angleDeltaValid),
    .angleDelta(angleDelta), .turnsPosition(turnsPosition),
    .sharedOutputPinOwner(sharedOutputPinOwner), .interfaceErrorWarning(interfaceErrorWarning));

// File: dv/ssrp_port_tb.sv
// self-checking bench for the serial register port
`timescale 1ns/1ps
module ssrp_port_tb;
    logic        clock = 1'b0, sys_rst = 1'b1, deltaValid = 1'b0, sessionOn = 1'b0;
    logic        spiSclk, spiCsN, spiMosi, spiMiso, spiMisoOe, warn;
    logic [20:0] delta = '0, turns, val;
    logic [3:0]  owner;
    logic [19:0] rx;
    int          err_count = 0, compares = 0;
    initial forever #4 clock = ~clock;
    ssrp_host_model i_ssrp_host_model (.spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi),
        .spiMiso(spiMiso));
    ssrp_port i_ssrp_port (.clock(clock), .sys_rst(sys_rst), .spiSclk(spiSclk),
        .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe),
        .supplyWrValid(1'b0), .supplyWrAddr(6'h00), .supplyWrData(8'h00),
        .supplySessionActive(sessionOn), .systemAllOk(1'b1), .angleDeltaValid(deltaValid),
        .angleDelta(delta), .sensedAngle(12'h000), .turnsPosition(turns),
        .sharedOutputPinOwner(owner), .interfaceErrorWarning(warn));
    function automatic logic [3:0] crc4(input logic [15:0] w);
        logic [3:0] c;
        c = 4'hF;
        for (int i = 15; i >= 0; i--) c = {c[2:1], c[0] ^ w[i] ^ c[3], w[i] ^ c[3]};
        return c;
    endfunction
    function automatic logic [19:0] frm(input logic rw, input logic [5:0] a, input logic [7:0] d);
        return {1'b0, rw, a, d, crc4({1'b0, rw, a, d})};
    endfunction
    task automatic check(input logic [25:0] seen, input logic [25:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d, input int n = 16);
        i_ssrp_host_model.xfer(frm(1'b1, a, d), n, rx);
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] exp);
        i_ssrp_host_model.xfer(frm(1'b0, a, 8'h00), 16, rx);
        i_ssrp_host_model.xfer(frm(1'b0, a, 8'h00), 20, rx);
        check(rx[19:4], exp);
        check(rx[3:0], crc4(exp));
    endtask
    task automatic results();
        if (err_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        #400000;
        err_count++;
        results();
    end
    initial
    begin
        void'($urandom(32'h0000_60ea));
        repeat (3) @(posedge clock);
        #1 sys_rst = 1'b0;
        repeat (3) @(posedge clock);
        check({turns, owner, warn}, {21'h0_0000, ssrp_pkg::OWN_SPI, 1'b0});
        wr(ssrp_pkg::ADDR_EXT_WR_LOW, 8'h00, 20);
        check(rx, {16'h0000, crc4(16'h0000)});
        rd(ssrp_pkg::ADDR_EXT_WR_LOW, 16'h0000);
        rd(ssrp_pkg::ADDR_STATUS, 16'h0001);
        val = 21'($urandom);
        for (int i = 0; i < 4; i++) wr(6'(4 + i), 8'({11'h000, val} >> (24 - 8 * i)));
        wr(ssrp_pkg::ADDR_CMD + 6'h01, ssrp_pkg::CMD_LOAD_ACCUM);
        wr(ssrp_pkg::ADDR_CMD, ssrp_pkg::CMD_TRIGGER_KEY);
        check(turns, val);
        rd(ssrp_pkg::ADDR_CMD, 16'h0000);
        rd(ssrp_pkg::ADDR_TURNS_HIGH, {11'h000, val[20:16]});
        rd(ssrp_pkg::ADDR_TURNS_LOW + 6'h01, {8'h00, val[7:0]});
        wr(ssrp_pkg::ADDR_TURNS_LOW, ~val[15:8], 20);
        check(turns, val);
        wr(ssrp_pkg::ADDR_EXT_WR_HIGH, 8'h55, 15);
        check(warn, 1'b1);
        rd(ssrp_pkg::ADDR_EXT_WR_HIGH, {11'h000, val[20:16]});
        @(posedge clock);
        #1 deltaValid = 1'b1;
        delta = 21'($urandom_range(255));
        @(posedge clock);
        #1 deltaValid = 1'b0;
        @(posedge clock);
        check(turns, val + delta);
        wr(ssrp_pkg::ADDR_CMD + 6'h01, ssrp_pkg::CMD_RESET_TURNS);
        wr(ssrp_pkg::ADDR_CMD, ssrp_pkg::CMD_TRIGGER_KEY);
        check(turns, 21'h0_0000);
        // config word 0 gets the late option: only 17-clock frames from here on
        wr(ssrp_pkg::ADDR_EXT_WR_LOW + 6'h01, 8'h10);
        wr(ssrp_pkg::ADDR_EXT_WR_CMD + 6'h01, 8'h01);
        i_ssrp_host_model.xfer(frm(1'b0, ssrp_pkg::ADDR_EXT_WR_CMD, 8'h00), 17, rx);
        i_ssrp_host_model.xfer(frm(1'b0, ssrp_pkg::ADDR_EXT_WR_CMD, 8'h00), 17, rx);
        check(rx[16:0], {16'h0002, crc4(16'h0002)} >> 3);
        #1 sessionOn = 1'b1;
        repeat (3) @(posedge clock);
        check(owner, ssrp_pkg::OWN_SUPPLY);
        results();
    end
endmodule
